/* File: logic/rsp_pkg.sv */
// Constants for the return-address stack: register map, field layout, reset values.
`default_nettype none
package rsp_pkg;
  // Pointer
  localparam int           PTR_W       = 5;
  localparam logic [4:0]   PTR_EMPTY   = 5'h00;
  localparam logic [4:0]   PTR_ONE     = 5'h01;
  localparam logic [4:0]   PTR_MAX     = 5'h1F;
  localparam logic [4:0]   PTR_LAST_OK = 5'h1E;
  // Register bus
  localparam int           ADDR_W      = 4;
  localparam int           DATA_W      = 8;
  localparam logic [3:0]   OFS_STATUS  = 4'h0;
  localparam logic [3:0]   OFS_TOP_LOW = 4'h1;
  localparam logic [3:0]   OFS_TOP_HI  = 4'h2;
  localparam logic [3:0]   OFS_TOP_UP  = 4'h3;
  localparam logic [3:0]   OFS_CTRL    = 4'h4;
  localparam logic [3:0]   OFS_IRQ_ST  = 4'h5;
  localparam logic [3:0]   OFS_IRQ_CLR = 4'h6;
  localparam logic [3:0]   OFS_IRQ_EN  = 4'h7;
  localparam logic [7:0]   RD_UNMAPPED = 8'h00;
  // Pointer status fields
  localparam int           FULL_BIT    = 7;
  localparam int           UNF_BIT     = 6;
  localparam int           PTR_MSB     = 4;
  localparam int           PTR_LSB     = 0;
  // Control register
  localparam int           CTRL_OVF_EN = 0;
  localparam logic         OVF_EN_RST  = 1'b1;
  // Interrupt events
  localparam int           IRQ_N       = 3;
  localparam int           IRQ_FULL    = 0;
  localparam int           IRQ_UNF     = 1;
  localparam int           IRQ_OVR     = 2;
  localparam logic [2:0]   IRQ_RST     = 3'h0;
  // Top entry byte lanes
  localparam logic [1:0]   LANE_LOW    = 2'h0;
  localparam logic [1:0]   LANE_HIGH   = 2'h1;
  localparam logic [1:0]   LANE_UPPER  = 2'h2;
  localparam int           WORD_W      = 24;
  localparam int           PC_W_MIN    = 9;
  // Increment stored on the overflowing push
  localparam int           PC_OVF_INC  = 2;
endpackage : rsp_pkg
`default_nettype wire

/* File: logic/rsp_return_stack.sv */
// Return-address stack with pointer status, top-entry access and interrupt.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rsp_return_stack #(
  parameter int PC_W = 21
) (
  // Clock and resets
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  input  wire logic                        DEV_RST,
  // Sequencer operations
  input  wire logic                        PUSH,
  input  wire logic                        POP,
  input  wire logic [PC_W-1:0]             PUSH_PC,
  output logic      [PC_W-1:0]             POP_PC,
  output logic                             POP_DONE,
  output logic                             OVF_RESET,
  // Register port
  input  wire logic [rsp_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [rsp_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [rsp_pkg::DATA_W-1:0]  RDATA,
  // Interrupt
  output logic                             IRQ
);

  if (PC_W < rsp_pkg::PC_W_MIN || PC_W > rsp_pkg::WORD_W) begin : g_chk
    $error("PC_W must fit in the three top-entry byte registers");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte access helpers

  function automatic logic [7:0] get_byte(input logic [PC_W-1:0] w, input logic [1:0] lane);
    logic [rsp_pkg::WORD_W-1:0] wide;
    wide = rsp_pkg::WORD_W'(w);
    case (lane)
      rsp_pkg::LANE_LOW:   get_byte = wide[7:0];
      rsp_pkg::LANE_HIGH:  get_byte = wide[15:8];
      rsp_pkg::LANE_UPPER: get_byte = wide[23:16];
      default:             get_byte = 8'h00;
    endcase
  endfunction : get_byte

  function automatic logic [PC_W-1:0] set_byte(input logic [PC_W-1:0] w, input logic [1:0] lane,
                                               input logic [7:0] d);
    logic [rsp_pkg::WORD_W-1:0] wide;
    wide = rsp_pkg::WORD_W'(w);
    case (lane)
      rsp_pkg::LANE_LOW:   wide[7:0]   = d;
      rsp_pkg::LANE_HIGH:  wide[15:8]  = d;
      rsp_pkg::LANE_UPPER: wide[23:16] = d;
      default:             wide        = wide;
    endcase
    set_byte = wide[PC_W-1:0];
  endfunction : set_byte

  // Register select; one place decides what a write strobe addresses
  function automatic logic addr_is(input logic [rsp_pkg::ADDR_W-1:0] a,
                                   input logic [rsp_pkg::ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // Top entry lanes occupy three neighbouring offsets
  function automatic logic addr_is_top(input logic [rsp_pkg::ADDR_W-1:0] a);
    addr_is_top = addr_is(a, rsp_pkg::OFS_TOP_LOW) | addr_is(a, rsp_pkg::OFS_TOP_HI) |
                  addr_is(a, rsp_pkg::OFS_TOP_UP);
  endfunction : addr_is_top

  // Pointer steps wrap inside five bits; callers keep them in range
  function automatic logic [rsp_pkg::PTR_W-1:0] ptr_step(input logic [rsp_pkg::PTR_W-1:0] p,
                                                          input logic up);
    ptr_step = up ? rsp_pkg::PTR_W'(p + rsp_pkg::PTR_ONE) :
                    rsp_pkg::PTR_W'(p - rsp_pkg::PTR_ONE);
  endfunction : ptr_step

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [rsp_pkg::PTR_W-1:0] ptr_r;
  logic [rsp_pkg::PTR_W-1:0] ptr_nxt;
  logic                      full_r;
  logic                      full_nxt;
  logic                      unf_r;
  logic                      unf_nxt;
  logic                      ovf_en_r;
  logic [rsp_pkg::IRQ_N-1:0] irq_st_r;
  logic [rsp_pkg::IRQ_N-1:0] irq_en_r;
  // Every nonzero pointer owns an entry; zero means empty
  localparam int             DEPTH = (1 << rsp_pkg::PTR_W) - 1;
  logic [PC_W-1:0]           mem_r [1:DEPTH];

  logic                      is_push;
  logic                      is_pop;
  logic                      top_valid;
  logic                      at_max;
  logic                      push_store;
  logic                      full_evt;
  logic                      ovf_evt;
  logic                      unf_evt;
  logic [PC_W-1:0]           top_word;
  logic [PC_W-1:0]           store_val;
  logic [rsp_pkg::PTR_W-1:0] ptr_inc;
  logic                      wr_status;
  logic                      wr_top;
  logic [1:0]                top_lane;
  logic [rsp_pkg::IRQ_N-1:0] irq_set;
  logic [rsp_pkg::IRQ_N-1:0] irq_clr;
  logic                      core_busy;
  logic                      wr_ctrl;
  logic                      wr_irq_clr;
  logic                      wr_irq_en;
  logic                      full_clr;
  logic                      unf_clr;
  logic [rsp_pkg::DATA_W-1:0] rdata_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Operation decode

  // Push outranks a simultaneous pop; the sequencer never issues both
  assign is_push    = PUSH;
  assign is_pop     = POP & ~PUSH;
  assign top_valid  = (ptr_r != rsp_pkg::PTR_EMPTY);
  assign at_max     = (ptr_r == rsp_pkg::PTR_MAX);
  assign ptr_inc    = ptr_step(ptr_r, 1'b1);
  assign top_word   = top_valid ? mem_r[ptr_r] : '0;

  assign push_store = is_push & ~at_max;
  assign full_evt   = is_push & ((ptr_r == rsp_pkg::PTR_LAST_OK) | at_max);
  assign ovf_evt    = full_evt & ovf_en_r;
  assign unf_evt    = is_pop & ~top_valid;

  // store PC plus two on overflow
  assign store_val  = ovf_evt ? PC_W'(PUSH_PC + PC_W'(rsp_pkg::PC_OVF_INC)) : PUSH_PC;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Core operations take the cycle; a status or top-entry write beside one is dropped
  // Dropping is cheaper than queueing; software must retry if it matters
  assign core_busy  = PUSH | POP;
  assign wr_status  = WR & ~core_busy & addr_is(ADDR, rsp_pkg::OFS_STATUS);
  // no entry to write while the stack is empty
  assign wr_top     = WR & ~core_busy & top_valid & addr_is_top(ADDR);
  // Control and interrupt registers never collide with the stack
  assign wr_ctrl    = WR & addr_is(ADDR, rsp_pkg::OFS_CTRL);
  assign wr_irq_clr = WR & addr_is(ADDR, rsp_pkg::OFS_IRQ_CLR);
  assign wr_irq_en  = WR & addr_is(ADDR, rsp_pkg::OFS_IRQ_EN);
  // a written 0 clears a flag, a written 1 is ignored
  assign full_clr   = wr_status & ~WDATA[rsp_pkg::FULL_BIT];
  assign unf_clr    = wr_status & ~WDATA[rsp_pkg::UNF_BIT];
  assign top_lane   = (ADDR == rsp_pkg::OFS_TOP_LOW) ? rsp_pkg::LANE_LOW :
                      (ADDR == rsp_pkg::OFS_TOP_HI)  ? rsp_pkg::LANE_HIGH : rsp_pkg::LANE_UPPER;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer

  always_comb begin
    // Priority: reset, push, pop, software write
    // device reset and overflow reset zero the pointer
    if (DEV_RST || ovf_evt) begin
      ptr_nxt = rsp_pkg::PTR_EMPTY;
    end else if (is_push) begin
      ptr_nxt = at_max ? ptr_r : ptr_inc;
    // decrement after popping; stays at zero
    end else if (is_pop) begin
      ptr_nxt = top_valid ? ptr_step(ptr_r, 1'b0) : rsp_pkg::PTR_EMPTY;
    end else if (wr_status) begin
      ptr_nxt = WDATA[rsp_pkg::PTR_MSB:rsp_pkg::PTR_LSB];
    end else begin
      ptr_nxt = ptr_r;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ptr_r <= rsp_pkg::PTR_EMPTY;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags

  // writing 0 clears, writing 1 has no effect, set wins
  // device reset leaves both flags alone
  always_comb begin
    full_nxt = full_evt | (full_r & ~full_clr);
    unf_nxt  = unf_evt  | (unf_r  & ~unf_clr);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      full_r <= 1'b0;
      unf_r  <= 1'b0;
    end else begin
      full_r <= full_nxt;
      unf_r  <= unf_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 1; i <= DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push_store) begin
      mem_r[ptr_inc] <= store_val;
    // byte write into the top entry
    end else if (wr_top) begin
      mem_r[ptr_r] <= set_byte(mem_r[ptr_r], top_lane, WDATA);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer answers

  // POP_PC holds between pops so the sequencer may fetch it late
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      POP_PC    <= '0;
      POP_DONE  <= 1'b0;
      OVF_RESET <= 1'b0;
    end else begin
      POP_DONE  <= is_pop;
      OVF_RESET <= ovf_evt;
      if (is_pop) begin
        POP_PC <= top_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and interrupts

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ovf_en_r <= rsp_pkg::OVF_EN_RST;
    end else if (wr_ctrl) begin
      ovf_en_r <= WDATA[rsp_pkg::CTRL_OVF_EN];
    end
  end

  always_comb begin
    irq_set                   = '0;
    irq_set[rsp_pkg::IRQ_FULL] = full_evt;
    irq_set[rsp_pkg::IRQ_UNF]  = unf_evt;
    irq_set[rsp_pkg::IRQ_OVR]  = ovf_evt;
    irq_clr = wr_irq_clr ? WDATA[rsp_pkg::IRQ_N-1:0] : '0;
  end

  // Write-one-to-clear; a new event in the clearing cycle survives
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_st_r <= rsp_pkg::IRQ_RST;
    end else begin
      irq_st_r <= irq_set | (irq_st_r & ~irq_clr);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_en_r <= rsp_pkg::IRQ_RST;
    end else if (wr_irq_en) begin
      irq_en_r <= WDATA[rsp_pkg::IRQ_N-1:0];
    end
  end

  // Level output; drops only once every enabled cause is cleared
  assign IRQ = |(irq_st_r & irq_en_r);

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rdata_nxt = rsp_pkg::RD_UNMAPPED;
    if (RD) begin
      case (ADDR)
        // status layout, bit 5 reads zero
        rsp_pkg::OFS_STATUS: begin
          rdata_nxt                                    = '0;
          rdata_nxt[rsp_pkg::FULL_BIT]                 = full_r;
          rdata_nxt[rsp_pkg::UNF_BIT]                  = unf_r;
          rdata_nxt[rsp_pkg::PTR_MSB:rsp_pkg::PTR_LSB] = ptr_r;
        end
        rsp_pkg::OFS_TOP_LOW: rdata_nxt = get_byte(top_word, rsp_pkg::LANE_LOW);
        rsp_pkg::OFS_TOP_HI:  rdata_nxt = get_byte(top_word, rsp_pkg::LANE_HIGH);
        rsp_pkg::OFS_TOP_UP:  rdata_nxt = get_byte(top_word, rsp_pkg::LANE_UPPER);
        rsp_pkg::OFS_CTRL:    rdata_nxt = rsp_pkg::DATA_W'(ovf_en_r);
        rsp_pkg::OFS_IRQ_ST:  rdata_nxt = rsp_pkg::DATA_W'(irq_st_r);
        rsp_pkg::OFS_IRQ_EN:  rdata_nxt = rsp_pkg::DATA_W'(irq_en_r);
        // Clear register is write-only and reads as unmapped
        default:              rdata_nxt = rsp_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // Data from a flop; zero outside the read answer cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= rsp_pkg::RD_UNMAPPED;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

endmodule : rsp_return_stack
`default_nettype wire

/* File: sim/rsp_return_stack_props.sv */
// Port checker for the return-address stack
`timescale 1ns/1ps
`default_nettype none
module rsp_return_stack_props #(
  parameter int PC_W = 21
) (
  // Clock and resets
  input wire logic            CLK,
  input wire logic            ARST_N,
  input wire logic            DEV_RST,
  // Sequencer side
  input wire logic            PUSH,
  input wire logic            POP,
  input wire logic [PC_W-1:0] PUSH_PC,
  input wire logic [PC_W-1:0] POP_PC,
  input wire logic            POP_DONE,
  input wire logic            OVF_RESET,
  // Register port
  input wire logic [3:0]      ADDR,
  input wire logic [7:0]      WDATA,
  input wire logic            WR,
  input wire logic            RD,
  input wire logic [7:0]      RDATA,
  input wire logic            IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Device reset leaves an empty stack behind
  sequence s_rst_pop;
    DEV_RST ##1 (POP && !PUSH && !DEV_RST);
  endsequence
  sequence s_push_pop;
    DEV_RST ##1 (PUSH && !POP && !DEV_RST) ##1 (POP && !PUSH && !DEV_RST);
  endsequence
  property p_pop_done; POP && !PUSH |=> POP_DONE; endproperty
  property p_no_done; !(POP && !PUSH) |=> !POP_DONE; endproperty
  property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
  property p_bit5; RD && ADDR == rsp_pkg::OFS_STATUS |=> !RDATA[5]; endproperty
  property p_ovf; OVF_RESET |-> $past(PUSH); endproperty
  property p_irq_off; WR && ADDR == rsp_pkg::OFS_IRQ_EN && WDATA == 8'h00 |=> !IRQ; endproperty
  property p_empty_pop; s_rst_pop |=> POP_DONE && POP_PC == '0; endproperty
  property p_push_pop; s_push_pop |=> POP_PC == $past(PUSH_PC, 2); endproperty
  property p_ovf_pulse; OVF_RESET |=> !OVF_RESET; endproperty
  a_pop_done: assert property (p_pop_done)
    else $error("pop not acknowledged");
  a_no_done: assert property (p_no_done)
    else $error("stray pop acknowledge");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  a_bit5: assert property (p_bit5)
    else $error("status bit 5 set");
  a_ovf: assert property (p_ovf)
    else $error("overflow reset without push");
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables off");
  a_empty_pop: assert property (p_empty_pop)
    else $error("empty pop not zero");
  a_push_pop: assert property (p_push_pop)
    else $error("popped value differs from pushed");
  a_ovf_pulse: assert property (p_ovf_pulse)
    else $error("overflow reset longer than one cycle");
endmodule : rsp_return_stack_props
bind rsp_return_stack rsp_return_stack_props #(.PC_W(PC_W)) i_rsp_return_stack_props (
  .CLK(CLK), .ARST_N(ARST_N), .DEV_RST(DEV_RST), .PUSH(PUSH), .POP(POP),
  .PUSH_PC(PUSH_PC), .POP_PC(POP_PC), .POP_DONE(POP_DONE), .OVF_RESET(OVF_RESET),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
`default_nettype wire

/* File: sim/rsp_seq_model.sv */
// Instruction sequencer model issuing calls, returns, pushes and pops
`timescale 1ns/1ps
`default_nettype none
module rsp_seq_model #(
  parameter int PC_W = 21
) (
  input  wire logic            CLK,
  output logic                 PUSH,
  output logic                 POP,
  output logic [PC_W-1:0]      PUSH_PC
);
  initial begin
    PUSH = 1'b0;
    POP = 1'b0;
    PUSH_PC = '0;
  end
  task automatic op(input logic ps, input logic pp, input logic [PC_W-1:0] pc, input int gap);
    PUSH <= ps;
    POP <= pp;
    PUSH_PC <= pc;
    @(posedge CLK);
    // Gap zero keeps requests back to back; released value is scrambled
    if (gap > 0) begin
      PUSH <= 1'b0;
      POP <= 1'b0;
      PUSH_PC <= ~pc;
      repeat (gap) @(posedge CLK);
    end
  endtask : op
endmodule : rsp_seq_model
`default_nettype wire

/* File: sim/rsp_return_stack_tb_top.sv */
// Testbench for the return-address stack
`timescale 1ns/1ps
`default_nettype none
module rsp_return_stack_tb_top;
  localparam int   PC_W = 21;
  logic            CLK = 1'b0;
  logic            ARST_N = 1'b0;
  logic            DEV_RST = 1'b0;
  logic            WR = 1'b0;
  logic            RD = 1'b0;
  logic [3:0]      ADDR = 4'h0;
  logic [7:0]      WDATA = 8'h00;
  logic            PUSH, POP, POP_DONE, OVF_RESET, IRQ;
  logic [PC_W-1:0] PUSH_PC, POP_PC;
  logic [7:0]      RDATA, rd_val;
  logic [PC_W-1:0] ent [32];
  logic [4:0]      ptr = 5'h00;
  logic            full = 1'b0, unf = 1'b0, ovf_en = 1'b1;
  logic [31:0]     seed = 32'h931E2CB6;
  int              err_total = 0;
  int              samples_checked = 0;
  always #5 CLK = ~CLK;
  rsp_seq_model #(.PC_W(PC_W)) i_rsp_seq_model (.CLK(CLK), .PUSH(PUSH), .POP(POP),
    .PUSH_PC(PUSH_PC));
  rsp_return_stack #(.PC_W(PC_W)) i_rsp_return_stack (.CLK(CLK), .ARST_N(ARST_N),
    .DEV_RST(DEV_RST), .PUSH(PUSH), .POP(POP), .PUSH_PC(PUSH_PC), .POP_PC(POP_PC),
    .POP_DONE(POP_DONE), .OVF_RESET(OVF_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] st_exp();
    return {full, unf, 1'b0, ptr};
  endfunction : st_exp
  function automatic logic [7:0] top_byte(input int k);
    logic [23:0] w;
    w = 24'(ent[ptr]);
    return w[8*k +: 8];
  endfunction : top_byte
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 rd_val = RDATA;
    @(posedge CLK);
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({16'h0, rd_val}, {16'h0, e});
  endtask : rd_chk
  task automatic push(input logic [PC_W-1:0] pc, input int gap);
    logic hi;
    hi = ptr >= 5'h1E;
    i_rsp_seq_model.op(1'b1, 1'b0, pc, gap);
    if (ptr == 5'h1F || (hi && ovf_en)) begin
      if (ptr == 5'h1E) ent[31] = pc + PC_W'(rsp_pkg::PC_OVF_INC);
      if (ovf_en) ptr = 5'h00;
    end else begin
      ptr = ptr + 5'h01;
      ent[ptr] = pc;
    end
    if (hi) full = 1'b1;
  endtask : push
  task automatic pop();
    logic [PC_W-1:0] e;
    e = (ptr == 5'h00) ? '0 : ent[ptr];
    i_rsp_seq_model.op(1'b0, 1'b1, '0, 1);
    chk(24'(POP_PC), 24'(e));
    if (ptr == 5'h00) unf = 1'b1;
    else ptr = ptr - 5'h01;
  endtask : pop
  task automatic dev_reset();
    DEV_RST <= 1'b1;
    @(posedge CLK);
    DEV_RST <= 1'b0;
    ptr = 5'h00;
  endtask : dev_reset
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      push(seed[PC_W-1:0], int'(i == n - 1));
    end
  endtask : fill
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    close_out();
  end
  initial begin
    int n;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    rd_chk(rsp_pkg::OFS_STATUS, 8'h00);
    rd_chk(rsp_pkg::OFS_CTRL, 8'h01);
    rd_chk(4'h8, rsp_pkg::RD_UNMAPPED);
    for (int r = 0; r < 6; r++) begin
      n = 1 + int'(seed[3:0]);
      fill(n);
      rd_chk(rsp_pkg::OFS_STATUS, st_exp());
      for (int k = 0; k < 3; k++) rd_chk(4'(k + 1), top_byte(k));
      seed = lfsr(seed);
      bus(1'b1, rsp_pkg::OFS_TOP_LOW, seed[7:0]);
      ent[ptr][7:0] = seed[7:0];
      repeat (n - int'(seed[8])) pop();
    end
    // Underflow, then mask, unmask and clear the interrupt
    bus(1'b1, rsp_pkg::OFS_IRQ_EN, 8'h07);
    dev_reset();
    pop();
    chk(24'(IRQ), 24'h1);
    rd_chk(rsp_pkg::OFS_IRQ_ST, 8'h02);
    rd_chk(rsp_pkg::OFS_IRQ_EN, 8'h07);
    bus(1'b1, rsp_pkg::OFS_IRQ_EN, 8'h00);
    chk(24'(IRQ), 24'h0);
    bus(1'b1, rsp_pkg::OFS_IRQ_EN, 8'h07);
    bus(1'b1, rsp_pkg::OFS_IRQ_CLR, 8'h07);
    chk(24'(IRQ), 24'h0);
    bus(1'b1, rsp_pkg::OFS_STATUS, 8'hC3);
    ptr = 5'h03;
    rd_chk(rsp_pkg::OFS_STATUS, st_exp());
    bus(1'b1, rsp_pkg::OFS_STATUS, 8'h80);
    unf = 1'b0;
    ptr = 5'h00;
    rd_chk(rsp_pkg::OFS_STATUS, st_exp());
    dev_reset();
    seed = lfsr(seed);
    push(seed[PC_W-1:0], 0);
    pop();
    // Overflow with overflow reset enabled
    fill(31);
    rd_chk(rsp_pkg::OFS_STATUS, st_exp());
    bus(1'b1, rsp_pkg::OFS_STATUS, 8'hDF);
    ptr = 5'h1F;
    for (int k = 0; k < 3; k++) rd_chk(4'(k + 1), top_byte(k));
    bus(1'b1, rsp_pkg::OFS_STATUS, 8'h00);
    full = 1'b0;
    ptr = 5'h00;
    rd_chk(rsp_pkg::OFS_STATUS, 8'h00);
    // Saturating overflow, two extra pushes
    bus(1'b1, rsp_pkg::OFS_CTRL, 8'h00);
    ovf_en = 1'b0;
    fill(33);
    rd_chk(rsp_pkg::OFS_STATUS, st_exp());
    for (int k = 0; k < 3; k++) rd_chk(4'(k + 1), top_byte(k));
    close_out();
  end
endmodule : rsp_return_stack_tb_top
`default_nettype wire
